// >>> verilog/tcc_timer16.v
// Contract
// RULE1: 16-bit counter seen as two byte locations
// RULE2: high byte goes through shared latch
// RULE3: latch keeps value between host accesses
// RULE4: 3-bit clock select in control B
// RULE5: counter clears/counts per mode; select 0 stops
// RULE6: host counter write beats counting
// RULE7: internal count, direction, clear, top, bottom
// RULE8: mode field split over controls A, B
// RULE9: overflow flag set per mode, raises irq
// RULE10: matching edge copies counter into capture
// RULE11: capture flag same cycle; irq; clears
// RULE12: capture low read loads latch first
// RULE13: capture writable only in capture-top modes
// RULE14: trigger from pin or comparator select
// RULE15: software clears flag after source switch
// RULE16: inputs sampled like external clock pin
// RULE17: filter needs four equal samples
// RULE18: filter adds four system clocks
// RULE19: capture input off in capture-top modes
// RULE20: new capture overwrites unread value
// RULE21: driving capture pin by port triggers
// RULE22: software flips edge for duty cycle
// RULE23: bottom means counter 0x0000
// RULE24: top fixed 0xFF/0x1FF/0x3FF, compare A, capture
// RULE25: low byte access moves whole word at once
// RULE26: edge select set rising, clear falling
// RULE27: two-flop sync before filter and edge
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.vh"
module tcc_timer16 (
  // clock and reset
  input wire core_clk,
  input wire srst,
  // register bus
  input wire [3:0] busAddr,
  input wire busWrEn,
  input wire busRdEn,
  input wire [7:0] busWrData,
  output reg [7:0] busRdData,
  // pins and comparator
  input wire capturePin,
  input wire comparatorOutput,
  input wire externalClockPin,
  // interrupts
  input wire ovfIrqAck,
  input wire capIrqAck,
  output wire ovfIrq,
  output wire capIrq
);
  reg [7:0] ctrlA_q;
  reg [7:0] ctrlB_q;
  reg [7:0] irqMask_q;
  reg [7:0] cmpCtrlStatus_q;
  reg [7:0] latch_q;
  reg [15:0] counterValue_q;
  reg [15:0] captureReg_q;
  reg [15:0] compareA_q;
  reg countDown_q;
  reg ovfFlag_q;
  reg capFlag_q;
  reg [9:0] prescale_q;
  reg [1:0] extSync_q;
  reg extPrev_q;
  reg [1:0] pinSync_q;
  reg [1:0] cmpSync_q;
  reg [2:0] filtShift_q;
  reg filtOut_q;
  reg edgePrev_q;

  wire [3:0] waveformMode = {ctrlB_q[4:3], ctrlA_q[1:0]}; // see RULE8
  wire [2:0] clockSelect = ctrlB_q[2:0]; // see RULE4
  wire wrAny = busWrEn;
  wire rdAny = busRdEn;
  wire wrCntL = wrAny && (busAddr == `TCC_ADDR_CNTL);
  wire wrCapL = wrAny && (busAddr == `TCC_ADDR_CAPL);
  wire wrCmpL = wrAny && (busAddr == `TCC_ADDR_CMPAL);
  wire wrFlag = wrAny && (busAddr == `TCC_ADDR_IFLAG);

  // modes whose top comes from the capture register
  wire capTopMode = (waveformMode == 4'h8) || (waveformMode == 4'hA) ||
                    (waveformMode == 4'hC) || (waveformMode == 4'hE);
  wire cmpTopMode = (waveformMode == 4'h4) || (waveformMode == 4'h9) ||
                    (waveformMode == 4'hB) || (waveformMode == 4'hF);
  wire dualSlope = (waveformMode == 4'h1) || (waveformMode == 4'h2) ||
                   (waveformMode == 4'h3) || (waveformMode == 4'h8) ||
                   (waveformMode == 4'h9) || (waveformMode == 4'hA) ||
                   (waveformMode == 4'hB);
  // modes 0 and 13 wrap at max instead of clearing at top
  wire freeRun = (waveformMode == 4'h0) || (waveformMode == 4'hD);
  wire clearAtTopOnly = (waveformMode == 4'h4) || (waveformMode == 4'hC);

  reg [15:0] topValue;
  always @* begin
    case (waveformMode) // see RULE24
      4'h1, 4'h5: topValue = `TCC_TOP8;
      4'h2, 4'h6: topValue = `TCC_TOP9;
      4'h3, 4'h7: topValue = `TCC_TOP10;
      default: begin
        if (capTopMode) begin
          topValue = captureReg_q;
        end else if (cmpTopMode) begin
          topValue = compareA_q;
        end else begin
          topValue = `TCC_MAX;
        end
      end
    endcase
  end

  wire atTop = (counterValue_q == topValue); // see RULE7
  wire atBottom = (counterValue_q == `TCC_BOTTOM); // see RULE23
  wire atMax = (counterValue_q == `TCC_MAX);

  // external clock pin: synchronised, then edge detected
  wire extSampled = extSync_q[1];
  wire extRise = extSampled && !extPrev_q;
  wire extFall = !extSampled && extPrev_q;

  // prescaler taps run free, so the first tick after a select change may come early
  reg timerTick;
  always @* begin
    case (clockSelect) // see RULE4
      `TCC_CS_STOP: timerTick = 1'b0; // see RULE5
      `TCC_CS_DIV1: timerTick = 1'b1;
      `TCC_CS_DIV8: timerTick = (prescale_q[2:0] == 3'h7);
      `TCC_CS_DIV64: timerTick = (prescale_q[5:0] == 6'h3F);
      `TCC_CS_DIV256: timerTick = (prescale_q[7:0] == 8'hFF);
      `TCC_CS_DIV1024: timerTick = (prescale_q == 10'h3FF);
      `TCC_CS_EXTFALL: timerTick = extFall;
      default: timerTick = extRise;
    endcase
  end

  // count, direction and clear controls of the counter
  reg countClear;
  reg countDir_d;
  always @* begin
    countDir_d = countDown_q;
    countClear = 1'b0;
    if (dualSlope) begin
      if (countDown_q && atBottom) begin
        countDir_d = 1'b0;
      end else if (!countDown_q && (counterValue_q >= topValue)) begin
        countDir_d = 1'b1;
      end
    end else begin
      countDir_d = 1'b0;
      countClear = atTop && !freeRun;
    end
  end

  // overflow point depends on the mode
  reg ovfEvent;
  always @* begin
    if (!timerTick) begin
      ovfEvent = 1'b0;
    end else if (dualSlope) begin
      ovfEvent = atBottom && countDown_q;
    end else if (freeRun || clearAtTopOnly) begin
      ovfEvent = atMax;
    end else begin
      ovfEvent = atTop;
    end
  end

  // capture trigger chain
  wire pinSampled = pinSync_q[1];
  wire cmpSampled = cmpSync_q[1];
  wire trigRaw = cmpCtrlStatus_q[`TCC_CMPCS_SEL] ? cmpSampled : pinSampled; // see RULE14
  // three stored samples plus the live one form the window, so the filter costs exactly four cycles
  wire filtAllOne = &{filtShift_q, trigRaw};
  wire filtAllZero = ~|{filtShift_q, trigRaw};
  wire trigFiltered = ctrlB_q[`TCC_CTRLB_FILT] ? filtOut_q : trigRaw; // see RULE17
  wire edgeRising = ctrlB_q[`TCC_CTRLB_EDGE];
  // a source switch can look like an edge; software clears the flag afterwards
  wire captureEvent = !capTopMode && // see RULE19
                      (edgeRising ? (trigFiltered && !edgePrev_q) : (!trigFiltered && edgePrev_q)); // see RULE26

  always @(posedge core_clk) begin
    if (srst) begin
      extSync_q <= 2'h0;
      extPrev_q <= 1'b0;
      pinSync_q <= 2'h0;
      cmpSync_q <= 2'h0;
      filtShift_q <= 3'h0;
      filtOut_q <= 1'b0;
      // starts at the idle low level of the pins, so no false edge follows reset
      edgePrev_q <= 1'b0;
      prescale_q <= 10'h000;
    end else begin
      extSync_q <= {extSync_q[0], externalClockPin};
      extPrev_q <= extSampled;
      // the pin is sampled whatever drives it, port output included
      pinSync_q <= {pinSync_q[0], capturePin}; // see RULE27 see RULE21
      cmpSync_q <= {cmpSync_q[0], comparatorOutput}; // see RULE16
      // filter runs on the system clock, not on the prescaled tick
      filtShift_q <= {filtShift_q[1:0], trigRaw}; // see RULE18
      if (filtAllOne) begin
        filtOut_q <= 1'b1; // see RULE17
      end else if (filtAllZero) begin
        filtOut_q <= 1'b0;
      end
      edgePrev_q <= trigFiltered;
      prescale_q <= prescale_q + 10'h001;
    end
  end

  // host registers, counter and capture
  // one latch serves every word register; an interrupt between two byte accesses can corrupt a transfer
  always @(posedge core_clk) begin
    if (srst) begin
      ctrlA_q <= `TCC_CTRL_RST;
      ctrlB_q <= `TCC_CTRL_RST;
      irqMask_q <= `TCC_CTRL_RST;
      cmpCtrlStatus_q <= `TCC_CTRL_RST;
      latch_q <= `TCC_CTRL_RST;
      counterValue_q <= `TCC_WORD_RST;
      captureReg_q <= `TCC_WORD_RST;
      compareA_q <= `TCC_WORD_RST;
      countDown_q <= 1'b0;
      busRdData <= `TCC_CTRL_RST;
    end else begin
      if (wrAny) begin
        case (busAddr)
          `TCC_ADDR_CTRLA: ctrlA_q <= busWrData;
          `TCC_ADDR_CTRLB: ctrlB_q <= busWrData;
          `TCC_ADDR_IMASK: irqMask_q <= busWrData;
          `TCC_ADDR_CMPCS: cmpCtrlStatus_q <= busWrData;
          `TCC_ADDR_CNTH, `TCC_ADDR_CAPH, `TCC_ADDR_CMPAH: latch_q <= busWrData; // see RULE2 see RULE3
          default: begin
          end
        endcase
      end
      if (rdAny) begin
        case (busAddr)
          `TCC_ADDR_CTRLA: busRdData <= ctrlA_q;
          `TCC_ADDR_CTRLB: busRdData <= ctrlB_q;
          `TCC_ADDR_CNTL: begin
            busRdData <= counterValue_q[7:0]; // see RULE1
            latch_q <= counterValue_q[15:8]; // see RULE25
          end
          `TCC_ADDR_CAPL: begin
            busRdData <= captureReg_q[7:0];
            latch_q <= captureReg_q[15:8]; // see RULE12
          end
          `TCC_ADDR_CNTH, `TCC_ADDR_CAPH: busRdData <= latch_q; // see RULE2
          `TCC_ADDR_CMPAL: busRdData <= compareA_q[7:0];
          `TCC_ADDR_CMPAH: busRdData <= compareA_q[15:8];
          `TCC_ADDR_IMASK: busRdData <= irqMask_q;
          `TCC_ADDR_IFLAG: busRdData <= {2'h0, capFlag_q, 4'h0, ovfFlag_q};
          `TCC_ADDR_CMPCS: busRdData <= cmpCtrlStatus_q;
          default: busRdData <= 8'h00;
        endcase
      end
      if (wrCmpL) begin
        compareA_q <= {latch_q, busWrData};
      end
      if (wrCapL && capTopMode) begin
        captureReg_q <= {latch_q, busWrData}; // see RULE13
      end else if (captureEvent) begin
        captureReg_q <= counterValue_q; // see RULE10 see RULE20
      end
      if (wrCntL) begin
        counterValue_q <= {latch_q, busWrData}; // see RULE6 see RULE25
      end else if (timerTick) begin
        countDown_q <= countDir_d;
        if (countClear) begin
          counterValue_q <= `TCC_BOTTOM; // see RULE5
        end else if (countDir_d) begin
          counterValue_q <= counterValue_q - 16'h0001;
        end else begin
          counterValue_q <= counterValue_q + 16'h0001;
        end
      end
    end
  end

  // flags: a set in the same cycle as a clear wins
  wire ovfClear = ovfIrqAck || (wrFlag && busWrData[`TCC_IRQ_OVF]);
  wire capClear = capIrqAck || (wrFlag && busWrData[`TCC_IRQ_CAP]);
  always @(posedge core_clk) begin
    if (srst) begin
      ovfFlag_q <= 1'b0;
      capFlag_q <= 1'b0;
    end else begin
      if (ovfEvent) begin
        ovfFlag_q <= 1'b1; // see RULE9
      end else if (ovfClear) begin
        ovfFlag_q <= 1'b0;
      end
      if (captureEvent) begin
        capFlag_q <= 1'b1; // see RULE11
      end else if (capClear) begin
        capFlag_q <= 1'b0;
      end
    end
  end

  assign ovfIrq = ovfFlag_q && irqMask_q[`TCC_IRQ_OVF]; // see RULE9
  assign capIrq = capFlag_q && irqMask_q[`TCC_IRQ_CAP]; // see RULE11
endmodule
`default_nettype wire

// >>> verilog/tcc_regs.vh
`ifndef TCC_REGS_VH
`define TCC_REGS_VH
// register indices on the 8-bit bus
`define TCC_ADDR_CTRLA 4'h0
`define TCC_ADDR_CTRLB 4'h1
`define TCC_ADDR_CNTL 4'h2
`define TCC_ADDR_CNTH 4'h3
`define TCC_ADDR_CAPL 4'h4
`define TCC_ADDR_CAPH 4'h5
`define TCC_ADDR_CMPAL 4'h6
`define TCC_ADDR_CMPAH 4'h7
`define TCC_ADDR_IMASK 4'h8
`define TCC_ADDR_IFLAG 4'h9
`define TCC_ADDR_CMPCS 4'hA
// field positions
`define TCC_CTRLB_FILT 7
`define TCC_CTRLB_EDGE 6
`define TCC_IRQ_OVF 0
`define TCC_IRQ_CAP 5
`define TCC_CMPCS_SEL 2
// reset values
`define TCC_CTRL_RST 8'h00
`define TCC_WORD_RST 16'h0000
// fixed tops and extremes
`define TCC_TOP8 16'h00FF
`define TCC_TOP9 16'h01FF
`define TCC_TOP10 16'h03FF
`define TCC_MAX 16'hFFFF
`define TCC_BOTTOM 16'h0000
// clock select codes
`define TCC_CS_STOP 3'h0
`define TCC_CS_DIV1 3'h1
`define TCC_CS_DIV8 3'h2
`define TCC_CS_DIV64 3'h3
`define TCC_CS_DIV256 3'h4
`define TCC_CS_DIV1024 3'h5
`define TCC_CS_EXTFALL 3'h6
// filter window in samples
`define TCC_FILT_LEN 4
`endif

// >>> sim/tcc_timer16_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_timer16_properties (
  // clock and reset
  input wire core_clk,
  input wire srst,
  // register bus
  input wire [3:0] busAddr,
  input wire busWrEn,
  input wire busRdEn,
  input wire [7:0] busWrData,
  input wire [7:0] busRdData,
  // pins and interrupts
  input wire capturePin,
  input wire comparatorOutput,
  input wire ovfIrqAck,
  input wire capIrqAck,
  input wire ovfIrq,
  input wire capIrq
);
  logic [4:0] pinQuiet_q;
  logic [4:0] wrQuiet_q;
  logic pinPrev_q;
  logic cmpPrev_q;
  logic [2:0] csSel_q;
  logic modeZero_q;
  logic ctrlAZero_q;
  logic rdLo;
  logic rdHi;
  assign rdLo = busRdEn && busAddr == 4'h2;
  assign rdHi = busRdEn && (busAddr == 4'h3 || busAddr == 4'h5);
  // shadows of the clock select and mode, so stopped or free-running phases are known
  always @(posedge core_clk) begin
    pinPrev_q <= capturePin;
    cmpPrev_q <= comparatorOutput;
    if (srst || capturePin != pinPrev_q || comparatorOutput != cmpPrev_q) pinQuiet_q <= 5'h00;
    else if (pinQuiet_q != 5'h1F) pinQuiet_q <= pinQuiet_q + 5'h01;
    if (srst || busWrEn) wrQuiet_q <= 5'h00;
    else if (wrQuiet_q != 5'h1F) wrQuiet_q <= wrQuiet_q + 5'h01;
    if (srst) csSel_q <= 3'h0;
    else if (busWrEn && busAddr == 4'h1) csSel_q <= busWrData[2:0];
    if (srst) modeZero_q <= 1'b1;
    else if (busWrEn && busAddr == 4'h1) modeZero_q <= busWrData[4:3] == 2'h0;
    if (srst) ctrlAZero_q <= 1'b1;
    else if (busWrEn && busAddr == 4'h0) ctrlAZero_q <= busWrData[1:0] == 2'h0;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_rd_data_hold: assert property (!busRdEn |=> $stable(busRdData))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (busRdEn && busAddr > 4'hA |=> busRdData == 8'h00)
    else $error("unmapped read not zero");
  a_latch_stable: assert property (rdHi ##1 rdHi |=> $stable(busRdData))
    else $error("high byte latch changed on high read");
  a_latch_write: assert property (busWrEn && busAddr == 4'h3 ##1 busRdEn && busAddr == 4'h3
    |=> busRdData == $past(busWrData, 2))
    else $error("latch does not return written high byte");
  a_count_stop: assert property (csSel_q == 3'h0 && rdLo ##1 rdLo |=> $stable(busRdData))
    else $error("stopped counter moved");
  a_count_step: assert property (csSel_q == 3'h1 && modeZero_q && ctrlAZero_q && rdLo ##1 rdLo
    |=> busRdData == $past(busRdData) + 8'h01)
    else $error("counter did not step by one");
  a_ovf_clear: assert property (csSel_q == 3'h0 && (ovfIrqAck || busWrEn && busAddr == 4'h9 && busWrData[0])
    |=> !ovfIrq)
    else $error("overflow flag not cleared");
  a_cap_clear: assert property (pinQuiet_q > 5'h0A && wrQuiet_q > 5'h0A && (capIrqAck || busWrEn
    && busAddr == 4'h9 && busWrData[5]) |=> !capIrq)
    else $error("capture flag not cleared");
  a_cap_latency: assert property ($rose(capIrq) && wrQuiet_q > 5'h09
    |-> pinQuiet_q == 5'h02 || pinQuiet_q == 5'h06)
    else $error("capture flag at wrong delay after input change");
  c_capture: cover property ($rose(capIrq));
  c_overflow: cover property ($rose(ovfIrq));
  c_count_step: cover property (csSel_q == 3'h1 && rdLo ##1 rdLo);
endmodule
bind tcc_timer16 tcc_timer16_properties tcc_timer16_properties_inst (
  .core_clk(core_clk), .srst(srst), .busAddr(busAddr), .busWrEn(busWrEn), .busRdEn(busRdEn),
  .busWrData(busWrData), .busRdData(busRdData), .capturePin(capturePin),
  .comparatorOutput(comparatorOutput), .ovfIrqAck(ovfIrqAck), .capIrqAck(capIrqAck),
  .ovfIrq(ovfIrq), .capIrq(capIrq));
`default_nettype wire

// >>> sim/tcc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_cpu_model (
  // clock
  input wire core_clk,
  // register bus
  output logic [3:0] busAddr,
  output logic busWrEn,
  output logic busRdEn,
  output logic [7:0] busWrData,
  input wire [7:0] busRdData,
  // interrupt service
  output logic ovfIrqAck,
  output logic capIrqAck
);
  initial begin
    busAddr = 4'h0;
    busWrEn = 1'b0;
    busRdEn = 1'b0;
    busWrData = 8'h00;
    ovfIrqAck = 1'b0;
    capIrqAck = 1'b0;
  end
  // entered at a falling edge; strobes stay up so cycles can run back to back
  task wr(input logic [3:0] a, input logic [7:0] d);
    busAddr = a;
    busWrData = d;
    busWrEn = 1'b1;
    busRdEn = 1'b0;
    @(negedge core_clk);
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    busAddr = a;
    busRdEn = 1'b1;
    busWrEn = 1'b0;
    @(negedge core_clk);
    d = busRdData;
  endtask
  // data lines toggle when released so a stale value is never mistaken for a write
  task idle;
    busWrEn = 1'b0;
    busRdEn = 1'b0;
    busWrData = ~busWrData;
    @(negedge core_clk);
  endtask
  task wr16(input logic [3:0] hiAddr, input logic [15:0] v);
    wr(hiAddr, v[15:8]);
    wr(hiAddr - 4'h1, v[7:0]);
  endtask
  task rd16(input logic [3:0] loAddr, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(loAddr, lo);
    rd(loAddr + 4'h1, hi);
    v = {hi, lo};
  endtask
  task ack(input logic o, input logic c);
    ovfIrqAck = o;
    capIrqAck = c;
    @(negedge core_clk);
    ovfIrqAck = 1'b0;
    capIrqAck = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> sim/tcc_timer16_test.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_timer16_test;
  logic core_clk, srst, capturePin, comparatorOutput, externalClockPin;
  wire [3:0] busAddr;
  wire busWrEn, busRdEn, ovfIrqAck, capIrqAck, ovfIrq, capIrq;
  wire [7:0] busWrData, busRdData;
  int error_cnt, checks_done, cu, cf;
  logic [15:0] v;
  logic [7:0] b;
  tcc_timer16 tcc_timer16_inst (
    .core_clk(core_clk), .srst(srst), .busAddr(busAddr), .busWrEn(busWrEn), .busRdEn(busRdEn),
    .busWrData(busWrData), .busRdData(busRdData), .capturePin(capturePin),
    .comparatorOutput(comparatorOutput), .externalClockPin(externalClockPin),
    .ovfIrqAck(ovfIrqAck), .capIrqAck(capIrqAck), .ovfIrq(ovfIrq), .capIrq(capIrq));
  tcc_cpu_model tcc_cpu_model_inst (
    .core_clk(core_clk), .busAddr(busAddr), .busWrEn(busWrEn), .busRdEn(busRdEn),
    .busWrData(busWrData), .busRdData(busRdData), .ovfIrqAck(ovfIrqAck), .capIrqAck(capIrqAck));
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task step(input int n);
    repeat (n) tcc_cpu_model_inst.idle();
  endtask
  task wait_cap(output int c);
    c = 0;
    while (capIrq !== 1'b1 && c < 20) begin
      tcc_cpu_model_inst.idle();
      c++;
    end
    if (c == 20) begin
      chk("capture wait", 1, 0);
      final_report();
    end
  endtask
  task t_regs;
    tcc_cpu_model_inst.rd(4'h1, b);
    chk("ctrlB reset", 8'h00, b);
    tcc_cpu_model_inst.rd16(4'h2, v);
    chk("counter reset", 16'h0000, v);
    tcc_cpu_model_inst.wr(4'hF, 8'h5A);
    tcc_cpu_model_inst.rd(4'hF, b);
    chk("unmapped", 8'h00, b);
    tcc_cpu_model_inst.wr16(4'h3, 16'h01FF);
    step(3);
    tcc_cpu_model_inst.rd16(4'h2, v);
    chk("counter word", 16'h01FF, v);
    $display("regs done");
  endtask
  task t_latch;
    tcc_cpu_model_inst.wr(4'h3, 8'h12);
    tcc_cpu_model_inst.rd(4'h3, b);
    chk("latch readback", 8'h12, b);
    tcc_cpu_model_inst.wr(4'h2, 8'h34);
    tcc_cpu_model_inst.wr(4'h6, 8'h56);
    tcc_cpu_model_inst.rd(4'h7, b);
    chk("compare high", 8'h12, b);
    tcc_cpu_model_inst.rd16(4'h2, v);
    chk("counter shared", 16'h1234, v);
    tcc_cpu_model_inst.rd(4'h3, b);
    chk("latch kept", 8'h12, b);
    $display("latch done");
  endtask
  task t_run;
    tcc_cpu_model_inst.wr(4'h8, 8'h21);
    tcc_cpu_model_inst.wr16(4'h3, 16'hFFFE);
    tcc_cpu_model_inst.wr(4'h1, 8'h01);
    cu = 0;
    while (ovfIrq !== 1'b1 && cu < 20) begin
      tcc_cpu_model_inst.idle();
      cu++;
    end
    chk("overflow", 1, ovfIrq);
    if (cu == 20) final_report();
    tcc_cpu_model_inst.ack(1'b1, 1'b0);
    chk("overflow ack", 0, ovfIrq);
    tcc_cpu_model_inst.wr16(4'h3, 16'h1000);
    tcc_cpu_model_inst.rd(4'h2, b);
    chk("write beats tick", 8'h00, b);
    tcc_cpu_model_inst.rd(4'h2, b);
    chk("tick", 8'h01, b);
    tcc_cpu_model_inst.wr(4'h1, 8'h07);
    externalClockPin = 1'b1;
    step(6);
    externalClockPin = 1'b0;
    step(6);
    tcc_cpu_model_inst.rd(4'h2, b);
    chk("external clock", 8'h04, b);
    tcc_cpu_model_inst.wr(4'h1, 8'h00);
    tcc_cpu_model_inst.rd(4'h2, b);
    chk("stopped first", 8'h04, b);
    tcc_cpu_model_inst.rd(4'h2, b);
    chk("stopped second", 8'h04, b);
    tcc_cpu_model_inst.wr(4'h0, 8'h01);
    tcc_cpu_model_inst.wr16(4'h3, 16'h00FE);
    tcc_cpu_model_inst.wr(4'h1, 8'h09);
    tcc_cpu_model_inst.rd(4'h2, b);
    chk("below fixed top", 8'hFE, b);
    tcc_cpu_model_inst.rd(4'h2, b);
    chk("fixed top", 8'hFF, b);
    tcc_cpu_model_inst.rd(4'h2, b);
    chk("cleared at top", 8'h00, b);
    chk("overflow at top", 1, ovfIrq);
    tcc_cpu_model_inst.wr(4'h1, 8'h00);
    tcc_cpu_model_inst.wr(4'h0, 8'h00);
    tcc_cpu_model_inst.wr(4'h9, 8'h01);
    chk("overflow write clear", 0, ovfIrq);
    $display("run done");
  endtask
  task t_capture;
    tcc_cpu_model_inst.wr16(4'h3, 16'h4321);
    tcc_cpu_model_inst.wr(4'h1, 8'h40);
    tcc_cpu_model_inst.wr(4'h9, 8'h21);
    step(12);
    capturePin = 1'b1;
    wait_cap(cu);
    tcc_cpu_model_inst.ack(1'b0, 1'b1);
    chk("capture ack", 0, capIrq);
    capturePin = 1'b0;
    step(12);
    chk("falling ignored", 0, capIrq);
    tcc_cpu_model_inst.wr16(4'h3, 16'h0BBB);
    step(1);
    capturePin = 1'b1;
    wait_cap(cf);
    tcc_cpu_model_inst.rd16(4'h4, v);
    chk("capture word", 16'h0BBB, v);
    tcc_cpu_model_inst.wr(4'h1, 8'hC0);
    tcc_cpu_model_inst.wr(4'h9, 8'h20);
    capturePin = 1'b0;
    step(2);
    capturePin = 1'b1;
    step(14);
    chk("glitch filtered", 0, capIrq);
    capturePin = 1'b0;
    step(12);
    capturePin = 1'b1;
    wait_cap(cf);
    chk("filter delay", 4, cf - cu);
    tcc_cpu_model_inst.wr(4'hA, 8'h04);
    tcc_cpu_model_inst.wr(4'h9, 8'h20);
    step(12);
    comparatorOutput = 1'b1;
    wait_cap(cf);
    chk("comparator source", 1, capIrq);
    tcc_cpu_model_inst.rd16(4'h4, v);
    chk("comparator word", 16'h0BBB, v);
    tcc_cpu_model_inst.wr(4'h1, 8'h80);
    step(12);
    tcc_cpu_model_inst.wr(4'h9, 8'h20);
    chk("flag write clear", 0, capIrq);
    comparatorOutput = 1'b0;
    wait_cap(cf);
    chk("falling capture", 7, cf);
    tcc_cpu_model_inst.wr(4'h1, 8'h18);
    tcc_cpu_model_inst.wr16(4'h5, 16'hABCD);
    tcc_cpu_model_inst.wr(4'h1, 8'h00);
    tcc_cpu_model_inst.wr16(4'h5, 16'h1122);
    tcc_cpu_model_inst.rd16(4'h4, v);
    chk("capture write gate", 16'hABCD, v);
    $display("capture done");
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    srst = 1'b1;
    capturePin = 1'b0;
    comparatorOutput = 1'b0;
    externalClockPin = 1'b0;
    repeat (3) @(negedge core_clk);
    srst = 1'b0;
    t_regs();
    t_latch();
    t_run();
    t_capture();
    final_report();
  end
endmodule
`default_nettype wire
